// ---- cps_params.svh ----
// Purpose: shared constants of the charger protection supervisor
// Assumes: 10 MHz core clock, APB register access
// Notes: offsets, CFG field positions, nonzero reset values and the event count live here
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define CPS_ADDR_CFG     12'h000
`define CPS_ADDR_FODTHR  12'h004
`define CPS_ADDR_LIMITS  12'h008
`define CPS_ADDR_STATUS  12'h00C
`define CPS_ADDR_MASK    12'h010
`define CPS_ADDR_STATE   12'h014

// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define CPS_CFG_IND_LSB  0
`define CPS_CFG_SPL_BIT  2
`define CPS_CFG_CAP_LSB  4
`define CPS_CFG_RST      32'h0000_1F40
`define CPS_FODTHR_RST   32'h0000_0100
`define CPS_LIMITS_RST   32'h00FA_00C8
`define CPS_NUM_EVT      6

// -----------------------------------------------------------------
// bridge drive codes: frequency in 500 Hz steps, duty in 0.1 % steps
// -----------------------------------------------------------------
`define CPS_FREQ_MIN     9'h0DC
`define CPS_FREQ_MAX     9'h19A
`define CPS_FREQ_START   9'h15E
`define CPS_DUTY_MAX     9'h1F4
`define CPS_DUTY_START   9'h0FA

`endif

// ---- cps_pkg.sv ----
// Purpose: types of the charger protection supervisor
// Assumes: nothing beyond the constants header
// Notes: flags arrive already synchronised to the core clock
package cps_pkg;

   // supervisor phases
   typedef enum logic [2:0] {
      CPS_OFF,
      CPS_SEARCH,
      CPS_COMM,
      CPS_XFER,
      CPS_FOREIGN
   } cps_state_t;

   // comparator flags from the analog side
   typedef struct packed {
      logic       temp_above_110;  // internal sensor above upper limit
      logic       temp_below_80;   // internal sensor below release level
      logic       junction_trip;   // hardware junction detector
      logic [1:0] stage_overcurrent; // one bit per output stage, over 5 A
      logic       therm_below_0v8; // thermistor_sense stop level
      logic       therm_above_1v1; // thermistor_sense resume level
      logic       therm_below_150m; // thermistor_sense grounded
   } cps_flags_t;

   // bridge drive word
   typedef struct packed {
      logic       enable;          // bridge switching on
      logic       floating;        // all stages undriven
      logic [1:0] reverse;         // per-stage current reversal
      logic [8:0] freq_code;       // switching frequency / 500 Hz
      logic [8:0] duty_code;       // duty cycle in 0.1 % steps
   } cps_drive_t;

endpackage : cps_pkg

// ---- cps_hyst.sv ----
// Purpose: set/release latch for a pair of threshold comparators
// Assumes: set and release flags never both high for long
// Notes: set wins over release in the same cycle
module cps_hyst (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_nrst,
   // comparator flags
   input  wire logic i_set,
   input  wire logic i_release,
   // latched condition
   output logic      o_active
);

   // -----------------------------------------------------------------
   // hysteresis latch
   // -----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_active <= 1'b0;
      end else if (i_set) begin
         o_active <= 1'b1;             // crossing the trip level
      end else if (i_release) begin
         o_active <= 1'b0;             // back past the release level
      end
   end

endmodule : cps_hyst

// ---- cps_indicator.sv ----
// Purpose: green/red indicator and buzzer drive
// Assumes: outputs are active high "on" requests to open-drain pads
// Notes: blink and beep lengths are parameters so sims can shorten them
module cps_indicator
   import cps_pkg::*;
#(
   parameter int BLINK_CYCLES = 5000000,
   parameter int BEEP_CYCLES  = 1000000
) (
   // clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   // status in
   input  wire logic [1:0] i_mode,
   input  wire cps_state_t i_state,
   input  wire logic       i_fault,
   input  wire logic       i_start,
   // indicator drive
   output logic            o_green,
   output logic            o_red,
   output logic            o_buzzer
);

   logic [31:0] blink_cnt;             // blink half-period counter
   logic        blink;                 // blink phase
   logic [31:0] beep_cnt;              // remaining beep cycles

   // blink phase generator
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         blink_cnt <= '0;
         blink     <= 1'b0;
      end else if (blink_cnt == 32'(BLINK_CYCLES - 1)) begin
         blink_cnt <= '0;
         blink     <= ~blink;
      end else begin
         blink_cnt <= blink_cnt + 32'h1;
      end
   end

   // lights: mode bit 0 blinks green while charging, mode bit 1 mutes buzzer
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_green <= 1'b0;
         o_red   <= 1'b0;
      end else begin
         o_green <= (i_state == CPS_XFER) && !i_fault && (!i_mode[0] || blink);
         o_red   <= i_fault || (i_state == CPS_FOREIGN && blink);
      end
   end

   // buzzer: one beep when power transfer starts
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         beep_cnt <= '0;
         o_buzzer <= 1'b0;
      end else begin
         if (i_start && !i_mode[1]) begin
            beep_cnt <= 32'(BEEP_CYCLES);
         end else if (beep_cnt != 32'h0) begin
            beep_cnt <= beep_cnt - 32'h1;
         end
         o_buzzer <= (beep_cnt != 32'h0);
      end
   end

endmodule : cps_indicator

// ---- cps_supervisor.sv ----
// Purpose: top of the charger protection supervisor
// Assumes: all inputs synchronous to I_CORE_CLK; APB slave for registers
// Notes: every output is a flip-flop; transfers take two access cycles
`include "cps_params.svh"
module cps_supervisor
   import cps_pkg::*;
#(
   parameter int BLINK_CYCLES = 5000000,
   parameter int BEEP_CYCLES  = 1000000
) (
   // clock and reset
   input  wire logic              I_CORE_CLK,
   input  wire logic              I_NRST,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [11:0]       PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic [31:0]            PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // supply and standby
   input  wire logic              I_MAIN_SUPPLY_RAIL_OK,
   input  wire logic              I_STANDBY_REQUEST,
   input  wire logic              I_SUPPLY_SAG,
   // receiver status from the demodulator
   input  wire logic              I_RX_PRESENT,
   input  wire logic              I_RX_IDENT_OK,
   input  wire logic              I_RX_IDENT_FAIL,
   input  wire logic              I_CTRL_VALID,
   input  wire logic signed [7:0] I_CTRL_ERR,
   input  wire logic              I_POWER_VALID,
   input  wire logic [15:0]       I_RX_POWER,
   input  wire logic [15:0]       I_TX_POWER,
   // comparator flags
   input  wire cps_pkg::cps_flags_t I_FLAGS,
   // power stage control
   output logic                   O_BIAS_EN,
   output logic                   O_CORE_EN,
   output cps_pkg::cps_drive_t    O_DRIVE,
   // user interface
   output logic                   O_GREEN_INDICATOR,
   output logic                   O_RED_INDICATOR,
   output logic                   O_BUZZER,
   // interrupt
   output logic                   O_IRQ
);

   // -----------------------------------------------------------------
   // declarations
   // -----------------------------------------------------------------
   cps_state_t  state;                 // supervisor phase
   cps_state_t  next_state;            // phase for next cycle
   logic [31:0] cfg;                   // indicator, limit enable, static cap
   logic [15:0] fod_thr;               // foreign_object_detect threshold
   logic [31:0] limits;                // thermal and supply duty caps
   logic [`CPS_NUM_EVT-1:0] status;    // sticky events
   logic [`CPS_NUM_EVT-1:0] mask;      // event enables
   logic [`CPS_NUM_EVT-1:0] evt;       // event pulses this cycle
   logic        operational;           // supply up and no standby
   logic        thermal_limit;         // internal over-temperature latched
   logic        therm_cold;            // thermistor stop latched
   logic        therm_disabled;        // thermistor protection off
   logic        charge_start;          // entering transfer this cycle
   logic        suspend;               // power withheld this cycle
   logic [8:0]  duty_cap;              // most restrictive duty ceiling
   logic [8:0]  freq;                  // frequency code
   logic [8:0]  duty;                  // duty code
   logic [16:0] power_gap;             // measured minus reported power
   logic        foreign_hit;           // gap over threshold
   logic        wr_en;                 // apb write at completing edge
   logic        rd_en;                 // apb read launch
   logic        addr_ok;               // address is mapped

   // -----------------------------------------------------------------
   // protection latches
   // -----------------------------------------------------------------
   // internal temperature: limit above 110, release below 80
   cps_hyst u_otp (
      .i_clk     (I_CORE_CLK),
      .i_nrst    (I_NRST),
      .i_set     (I_FLAGS.temp_above_110),
      .i_release (I_FLAGS.temp_below_80),
      .o_active  (thermal_limit)
   );

   // thermistor window: stop below 0.8 V, resume above 1.1 V
   cps_hyst u_ntc (
      .i_clk     (I_CORE_CLK),
      .i_nrst    (I_NRST),
      .i_set     (I_FLAGS.therm_below_0v8),
      .i_release (I_FLAGS.therm_above_1v1),
      .o_active  (therm_cold)
   );

   // -----------------------------------------------------------------
   // phase sequencing
   // -----------------------------------------------------------------
   assign operational  = I_MAIN_SUPPLY_RAIL_OK && !I_STANDBY_REQUEST;
   assign charge_start = (state == CPS_COMM) && (next_state == CPS_XFER);
   assign power_gap    = {1'b0, I_TX_POWER} - {1'b0, I_RX_POWER};
   assign foreign_hit  = I_POWER_VALID && !power_gap[16]
                         && (power_gap[15:0] > fod_thr);

   // next phase
   always_comb begin
      next_state = state;
      case (state)
         CPS_OFF: begin
            if (operational) next_state = CPS_SEARCH;
         end
         CPS_SEARCH: begin
            if (I_RX_PRESENT) next_state = CPS_COMM;
         end
         CPS_COMM: begin
            if (!I_RX_PRESENT || I_RX_IDENT_FAIL) begin
               next_state = CPS_SEARCH;  // unknown object gets nothing
            end else if (I_RX_IDENT_OK) begin
               next_state = CPS_XFER;
            end
         end
         CPS_XFER: begin
            if (!I_RX_PRESENT) begin
               next_state = CPS_SEARCH;
            end else if (foreign_hit) begin
               next_state = CPS_FOREIGN;
            end
         end
         CPS_FOREIGN: begin
            if (!I_RX_PRESENT) next_state = CPS_SEARCH; // stays until removal
         end
         default: next_state = CPS_OFF;
      endcase
      if (!operational) next_state = CPS_OFF;
   end

   // phase register
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         state <= CPS_OFF;
      end else begin
         state <= next_state;
      end
   end

   // thermistor disable decided once per charging start
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         therm_disabled <= 1'b0;
      end else if (charge_start) begin
         therm_disabled <= I_FLAGS.therm_below_150m;
      end
   end

   // -----------------------------------------------------------------
   // power action arbitration
   // -----------------------------------------------------------------
   // suspension beats limiting; floating beats everything
   assign suspend = (state != CPS_XFER) || (therm_cold && !therm_disabled);

   // lowest of static, thermal and supply ceilings
   always_comb begin
      duty_cap = cfg[`CPS_CFG_CAP_LSB +: 9];
      if (thermal_limit && limits[8:0] < duty_cap) begin
         duty_cap = limits[8:0];
      end
      if (cfg[`CPS_CFG_SPL_BIT] && I_SUPPLY_SAG && limits[24:16] < duty_cap) begin
         duty_cap = limits[24:16];
      end
      if (duty_cap > `CPS_DUTY_MAX) begin
         duty_cap = `CPS_DUTY_MAX;
      end
   end

   // -----------------------------------------------------------------
   // frequency and duty regulation
   // -----------------------------------------------------------------
   // more power: step frequency down, then duty up; less: the reverse
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         freq <= `CPS_FREQ_START;
         duty <= `CPS_DUTY_START;
      end else if (state != CPS_XFER) begin
         freq <= `CPS_FREQ_START;
         duty <= (`CPS_DUTY_START < duty_cap) ? `CPS_DUTY_START : duty_cap;
      end else if (duty > duty_cap) begin
         duty <= duty - 9'h001;
      end else if (I_CTRL_VALID && I_CTRL_ERR > 8'sh00) begin
         if (freq > `CPS_FREQ_MIN) begin
            freq <= freq - 9'h001;
         end else if (duty < duty_cap) begin
            duty <= duty + 9'h001;
         end
      end else if (I_CTRL_VALID && I_CTRL_ERR < 8'sh00) begin
         if (duty > 9'h000 && freq == `CPS_FREQ_MIN) begin
            duty <= duty - 9'h001;
         end else if (freq < `CPS_FREQ_MAX) begin
            freq <= freq + 9'h001;
         end
      end
   end

   // -----------------------------------------------------------------
   // output stage drive
   // -----------------------------------------------------------------
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_DRIVE   <= '0;
         O_BIAS_EN <= 1'b0;
         O_CORE_EN <= 1'b0;
      end else begin
         O_BIAS_EN         <= operational;
         O_CORE_EN         <= (state == CPS_COMM) || (state == CPS_XFER)
                              || (state == CPS_FOREIGN);
         O_DRIVE.floating  <= I_FLAGS.junction_trip;
         O_DRIVE.enable    <= !I_FLAGS.junction_trip && !suspend;
         O_DRIVE.reverse   <= I_FLAGS.junction_trip ? 2'b00
                              : I_FLAGS.stage_overcurrent;
         O_DRIVE.freq_code <= freq;
         O_DRIVE.duty_code <= suspend ? 9'h000 : duty;
      end
   end

   // -----------------------------------------------------------------
   // user indication
   // -----------------------------------------------------------------
   cps_indicator #(
      .BLINK_CYCLES (BLINK_CYCLES),
      .BEEP_CYCLES  (BEEP_CYCLES)
   ) u_ind (
      .i_clk    (I_CORE_CLK),
      .i_nrst   (I_NRST),
      .i_mode   (cfg[`CPS_CFG_IND_LSB +: 2]),
      .i_state  (state),
      .i_fault  (thermal_limit || I_FLAGS.junction_trip || (therm_cold && !therm_disabled)),
      .i_start  (charge_start),
      .o_green  (O_GREEN_INDICATOR),
      .o_red    (O_RED_INDICATOR),
      .o_buzzer (O_BUZZER)
   );

   // -----------------------------------------------------------------
   // events and interrupt
   // -----------------------------------------------------------------
   // bit 0 start, 1 foreign, 2 thermal, 3 junction, 4 overcurrent, 5 therm stop
   assign evt = {I_FLAGS.therm_below_0v8 && !therm_cold && !therm_disabled,
                 |I_FLAGS.stage_overcurrent,
                 I_FLAGS.junction_trip,
                 I_FLAGS.temp_above_110 && !thermal_limit,
                 (state == CPS_XFER) && foreign_hit,
                 charge_start};

   // sticky status, write one to clear, a new event wins
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         status <= '0;
      end else if (wr_en && PADDR == `CPS_ADDR_STATUS) begin
         status <= (status & ~PWDATA[`CPS_NUM_EVT-1:0]) | evt;
      end else begin
         status <= status | evt;
      end
   end

   // level interrupt from unmasked status
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= |(status & mask);
      end
   end

   // -----------------------------------------------------------------
   // apb slave
   // -----------------------------------------------------------------
   assign rd_en   = PSEL && PENABLE && !PREADY && !PWRITE;
   assign wr_en   = PSEL && PENABLE && PREADY && PWRITE;
   assign addr_ok = (PADDR == `CPS_ADDR_CFG) || (PADDR == `CPS_ADDR_FODTHR)
                    || (PADDR == `CPS_ADDR_LIMITS) || (PADDR == `CPS_ADDR_STATUS)
                    || (PADDR == `CPS_ADDR_MASK) || (PADDR == `CPS_ADDR_STATE);

   // ready one cycle into the access phase
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end else begin
         PREADY  <= PSEL && PENABLE && !PREADY;
         PSLVERR <= PSEL && PENABLE && !PREADY && !addr_ok;
      end
   end

   // writable registers
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         cfg     <= `CPS_CFG_RST;
         fod_thr <= 16'(`CPS_FODTHR_RST);
         limits  <= `CPS_LIMITS_RST;
         mask    <= '0;
      end else if (wr_en) begin
         if (PADDR == `CPS_ADDR_CFG) begin
            cfg <= PWDATA & 32'h0000_1FF7;
         end else if (PADDR == `CPS_ADDR_FODTHR) begin
            fod_thr <= PWDATA[15:0];
         end else if (PADDR == `CPS_ADDR_LIMITS) begin
            limits <= PWDATA & 32'h01FF_01FF;
         end else if (PADDR == `CPS_ADDR_MASK) begin
            mask <= PWDATA[`CPS_NUM_EVT-1:0];
         end
      end
   end

   // read data, launched with ready
   always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
      if (!I_NRST) begin
         PRDATA <= '0;
      end else if (rd_en) begin
         if (PADDR == `CPS_ADDR_CFG) begin
            PRDATA <= cfg;
         end else if (PADDR == `CPS_ADDR_FODTHR) begin
            PRDATA <= {16'h0000, fod_thr};
         end else if (PADDR == `CPS_ADDR_LIMITS) begin
            PRDATA <= limits;
         end else if (PADDR == `CPS_ADDR_STATUS) begin
            PRDATA <= 32'(status);
         end else if (PADDR == `CPS_ADDR_MASK) begin
            PRDATA <= 32'(mask);
         end else if (PADDR == `CPS_ADDR_STATE) begin
            PRDATA <= {3'h0, therm_disabled, therm_cold, thermal_limit, duty,
                       freq, 5'h00, state};
         end else begin
            PRDATA <= '0;                  // unmapped reads zero
         end
      end
   end

endmodule : cps_supervisor

// ---- cps_supervisor_sva.sv ----
// Purpose: port checks of the supervisor
// Assumes: one clock domain, async low reset
// Notes: bound to every supervisor instance
`include "cps_params.svh"
module cps_chk
   import cps_pkg::*;
(
   input wire logic                I_CORE_CLK, I_NRST, I_MAIN_SUPPLY_RAIL_OK,
   input wire logic                I_STANDBY_REQUEST, O_BIAS_EN, O_CORE_EN,
   input wire cps_pkg::cps_flags_t I_FLAGS,
   input wire cps_pkg::cps_drive_t O_DRIVE
);
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_NRST);
   AST_BIAS_ON: assert property (I_MAIN_SUPPLY_RAIL_OK && !I_STANDBY_REQUEST |=> O_BIAS_EN)
      else $error("bias stayed off");
   AST_BIAS_OFF: assert property (I_STANDBY_REQUEST |=> !O_BIAS_EN)
      else $error("bias on in standby");
   AST_STANDBY_REQUEST_CORE: assert property (I_STANDBY_REQUEST [*3] |-> !O_CORE_EN)
      else $error("core on in standby");
   AST_XFER_CORE: assert property (O_DRIVE.enable |-> O_CORE_EN && !O_DRIVE.floating)
      else $error("drive without core");
   AST_JUNCTION: assert property (I_FLAGS.junction_trip [*3] |->
      !O_DRIVE.enable && O_DRIVE.reverse == 2'b00) else $error("drive during trip");
   AST_OC_REV: assert property (I_FLAGS.stage_overcurrent[1] [*3] ##0 O_DRIVE.enable |->
      O_DRIVE.reverse[1]) else $error("no current reversal");
   AST_DUTY_CAP: assert property (O_DRIVE.duty_code <= `CPS_DUTY_MAX)
      else $error("duty above top");
   AST_FREQ_BAND: assert property (O_DRIVE.enable |-> O_DRIVE.freq_code >= `CPS_FREQ_MIN &&
      O_DRIVE.freq_code <= `CPS_FREQ_MAX) else $error("frequency off band");
   // main scenarios reached
   cover property (O_DRIVE.enable);
   cover property (O_DRIVE.floating);
   cover property (O_DRIVE.reverse != 2'b00);
endmodule : cps_chk
bind cps_supervisor cps_chk u_chk (.I_CORE_CLK, .I_NRST, .I_MAIN_SUPPLY_RAIL_OK,
   .I_STANDBY_REQUEST, .O_BIAS_EN, .O_CORE_EN, .I_FLAGS, .O_DRIVE);

// ---- cps_rx_model.sv ----
// Purpose: receiver seen through the coil
// Assumes: one identity answer per placement
// Notes: data lines invert outside their valid pulse
module cps_rx_model (
   // clock, bench control, device status
   input  wire logic              i_clk, i_nrst, i_place, i_good, i_core_en, i_xfer,
   input  wire logic signed [7:0] i_err,
   // packets towards the device
   output logic                   o_present, o_ok, o_fail, o_ctrl, o_pwr,
   output logic signed [7:0]      o_err,
   output logic [15:0]            o_power
);
   logic [4:0] tick; // packet slot timer
   logic       sent; // identity answered
   logic       slot; // identity slot now
   assign slot = i_place && i_core_en && !sent && tick == 5'h1F;
   assign o_present = i_place;
   assign o_err = o_ctrl ? i_err : ~i_err;
   assign o_power = o_pwr ? 16'h1000 : 16'hEFFF;
   // one identity answer, then periodic control and power reports
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {tick, sent, o_ok, o_fail, o_ctrl, o_pwr} <= '0;
      end else begin
         tick <= tick + 5'h01;
         sent <= i_place && (sent || slot);
         {o_ok, o_fail} <= {slot && i_good, slot && !i_good};
         {o_ctrl, o_pwr} <= {i_xfer && tick == 5'h10, i_xfer && tick == 5'h08};
      end
   end
endmodule : cps_rx_model

// ---- tb.sv ----
// Purpose: self-checking bench of the supervisor
// Assumes: 10 MHz clock, receiver model at the coil
// Notes: reset reads from a table, protections by hand
`include "cps_params.svh"
`define CHK(g, x) begin checked++; if ((g) !== (x)) begin num_errors++; \
   $display("ERROR %0t got %h exp %h", $time, (g), (x)); end end
`define WT(c) begin n = 0; while (!(c) && n < 300) begin @(posedge clk); n++; end \
   if (n >= 300) begin num_errors++; summarize(); end end
`define CY(k) repeat (k) @(posedge clk);
`define FL(v) begin flags <= v; `CY(3) end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import cps_pkg::*;
   typedef struct {logic [11:0] a; logic [31:0] d; logic e;} cps_row_t;
   cps_row_t rows [6] = '{'{`CPS_ADDR_CFG, `CPS_CFG_RST, 1'b0},
      '{`CPS_ADDR_FODTHR, `CPS_FODTHR_RST, 1'b0}, '{`CPS_ADDR_LIMITS, `CPS_LIMITS_RST, 1'b0},
      '{`CPS_ADDR_STATUS, 32'h0, 1'b0}, '{`CPS_ADDR_MASK, 32'h0, 1'b0}, '{12'h018, 32'h0, 1'b1}};
   logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, standby_request = 1'b1;
   logic sup = 1'b1, sag = 1'b0, grn, red, buz;
   logic place = 1'b0, good = 1'b0, rdy, serr, e, bias, core, irq, pres, ok, fail, cv, pv;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0, prd, q;
   logic signed [7:0] step = 8'sh00, cerr;
   logic [15:0] rxp, txp = 16'h1000;
   cps_flags_t flags = '0;
   cps_drive_t drv;
   int num_errors = 0, checked = 0, n;
   always #50 clk = ~clk;
   cps_supervisor #(.BLINK_CYCLES(8), .BEEP_CYCLES(4)) dut (.I_CORE_CLK(clk), .I_NRST(nrst),
      .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd),
      .PREADY(rdy), .PSLVERR(serr), .I_MAIN_SUPPLY_RAIL_OK(sup), .I_STANDBY_REQUEST(standby_request),
      .I_SUPPLY_SAG(sag), .I_RX_PRESENT(pres), .I_RX_IDENT_OK(ok), .I_RX_IDENT_FAIL(fail),
      .I_CTRL_VALID(cv), .I_CTRL_ERR(cerr), .I_POWER_VALID(pv), .I_RX_POWER(rxp),
      .I_TX_POWER(txp), .I_FLAGS(flags), .O_BIAS_EN(bias), .O_CORE_EN(core), .O_DRIVE(drv),
      .O_GREEN_INDICATOR(grn), .O_RED_INDICATOR(red), .O_BUZZER(buz), .O_IRQ(irq));
   cps_rx_model rx (.i_clk(clk), .i_nrst(nrst), .i_place(place), .i_good(good),
      .i_core_en(core), .i_xfer(drv.enable), .i_err(step), .o_present(pres), .o_ok(ok),
      .o_fail(fail), .o_ctrl(cv), .o_pwr(pv), .o_err(cerr), .o_power(rxp));
   // counts, verdict, end of run
   task automatic summarize;
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : summarize
   // one apb transfer, held until ready
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      {psel, pwr, padr, pwd} <= {1'b1, w, a, d};
      `CY(1)
      pen <= 1'b1;
      `CY(1)
      `WT(rdy === 1'b1)
      {q, e} = {prd, serr};
      {psel, pen} <= 2'b00;
      `CY(1)
   endtask : apb
   initial begin
      `CY(10)
      `CHK(bias, 1'b0)
      nrst <= 1'b1;
      `CY(1)
      foreach (rows[i]) begin
         apb(1'b0, rows[i].a, 32'h0);
         `CHK({q, e}, {rows[i].d, rows[i].e})
      end
      `CHK(bias, 1'b0)
      standby_request <= 1'b0;
      `CY(3)
      `CHK(bias, 1'b1)
      apb(1'b1, `CPS_ADDR_MASK, 32'h2);
      place <= 1'b1;
      `WT(fail === 1'b1)
      `CY(40)
      `CHK({core, drv.enable}, 2'b10)
      place <= 1'b0;
      `CY(4)
      {good, place} <= 2'b11;
      `WT(drv.enable === 1'b1)
      `CHK({drv.freq_code, drv.duty_code, irq}, {`CPS_FREQ_START, `CPS_DUTY_START, 1'b0})
      `CHK({grn, buz}, 2'b11)
      step <= 8'sh05;
      `WT(cv === 1'b1)
      step <= 8'sh00;
      `CY(3)
      `CHK(drv.freq_code < `CPS_FREQ_START, 1'b1)
      `FL(8'h10)
      `CHK(drv.reverse, 2'b10)
      `FL(8'h20)
      `CHK({drv.floating, drv.enable, drv.reverse}, 4'b1000)
      `CHK({grn, red}, 2'b01)
      flags <= 8'h00;
      `WT(drv.enable === 1'b1)
      `FL(8'h04)
      `CHK(drv.enable, 1'b0)
      `FL(8'h00)
      `CHK(drv.enable, 1'b0)
      flags <= 8'h02;
      `WT(drv.enable === 1'b1)
      flags <= 8'h82;
      `CY(60)
      `CHK(drv.duty_code, 9'h0C8)
      flags <= 8'h02;
      apb(1'b0, `CPS_ADDR_STATE, 32'h0);
      `CHK(q[26], 1'b1)
      {place, flags} <= {1'b0, 8'h45};
      `CY(4)
      place <= 1'b1;
      `WT(drv.enable === 1'b1)
      `FL(8'h44)
      `CHK(drv.enable, 1'b1)
      // supply limiting: lower the supply ceiling, enable it, raise the sag flag
      apb(1'b1, `CPS_ADDR_LIMITS, 32'h00B4_00C8);
      apb(1'b1, `CPS_ADDR_CFG, 32'h0000_1F44);
      sag <= 1'b1;
      `CY(80)
      `CHK(drv.duty_code, 9'h0B4)
      sag <= 1'b0;
      txp <= 16'h1200;
      `WT(drv.enable === 1'b0)
      apb(1'b0, `CPS_ADDR_STATE, 32'h0);
      `CHK({q[2:0], drv.enable, irq}, 5'b10001)
      apb(1'b1, `CPS_ADDR_STATUS, 32'h2);
      `CY(1)
      `CHK(irq, 1'b0)
      // supply loss drops bias, core and drive
      sup <= 1'b0;
      `CY(3)
      `CHK({bias, core, drv.enable}, 3'b000)
      summarize();
   end
endmodule : tb
